// *** serial_side_model.sv ***
`timescale 1ns/100ps

module serial_side_model (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// bench control
	input  wire logic       rx_go,
	input  wire logic [4:0] rx_num,
	input  wire logic       drain,
	output logic            rx_busy,
	output logic      [7:0] tx_last,
	// block side
	input  wire logic       tx_stb,
	input  wire logic [7:0] tx_data,
	output logic            tx_req,
	output logic            rx_valid,
	output logic      [7:0] rx_data
);
	logic [4:0] left_q;
	logic [7:0] seq_q;

	assign rx_busy = (left_q != 5'h00) || rx_valid;

	// receive shifter: one character a cycle, line shows junk between
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			left_q   <= 5'h00;
			seq_q    <= 8'hA0;
			rx_valid <= 1'b0;
			rx_data  <= 8'h00;
		end
		else if (rx_go)
		begin
			left_q   <= rx_num;
			rx_valid <= 1'b0;
			rx_data  <= ~rx_data;
		end
		else if (left_q != 5'h00)
		begin
			left_q   <= left_q - 5'h01;
			rx_valid <= 1'b1;
			rx_data  <= seq_q;
			seq_q    <= seq_q + 8'h01;
		end
		else
		begin
			rx_valid <= 1'b0;
			rx_data  <= ~rx_data;
		end
	end

	// transmit shifter: asks every other cycle while draining
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_req  <= 1'b0;
			tx_last <= 8'h00;
		end
		else
		begin
			tx_req <= drain & ~tx_req;
			if (tx_stb)
				tx_last <= tx_data;
		end
	end
endmodule // serial_side_model

// *** uart_dma_pkg.sv ***
package uart_dma_pkg;

	// ********************************
	// sizes
	// ********************************
	localparam int            DATA_W     = 8;
	localparam int            PTR_W      = 4;
	localparam int            CNT_W      = 5;
	localparam logic [4:0]    FIFO_DEPTH = 5'h10;
	localparam logic [4:0]    HOLD_DEPTH = 5'h01;

	// ********************************
	// register map, byte addresses
	// ********************************
	localparam logic [7:0]    OFS_FIFO_CTRL = 8'h00;
	localparam logic [7:0]    OFS_ALT_FUNC  = 8'h04;
	localparam logic [7:0]    OFS_TX_DATA   = 8'h08;
	localparam logic [7:0]    OFS_RX_DATA   = 8'h0C;
	localparam logic [7:0]    OFS_STATUS    = 8'h10;

	// ********************************
	// fields and reset values
	// ********************************
	localparam logic [7:0]    FIFO_CTRL_RESET = 8'h00;
	localparam logic [7:0]    ALT_FUNC_RESET  = 8'h00;
	localparam int            ALT_SEL_LSB     = 1;
	localparam logic [1:0]    ALT_SEL_RX_RDY  = 2'h1;
	localparam int            ST_TX_CNT_LSB   = 0;
	localparam int            ST_RX_CNT_LSB   = 8;
	localparam int            ST_TX_INT       = 16;
	localparam int            ST_RX_INT       = 17;
	localparam int            ST_OVERRUN      = 18;
	localparam int            ST_TX_PIN       = 19;
	localparam int            ST_MF_PIN       = 20;

	// ********************************
	// receive trigger levels
	// ********************************
	localparam logic [4:0]    TRIG_LVL_0 = 5'h01;
	localparam logic [4:0]    TRIG_LVL_1 = 5'h04;
	localparam logic [4:0]    TRIG_LVL_2 = 5'h08;
	localparam logic [4:0]    TRIG_LVL_3 = 5'h0E;

	typedef struct packed {
		logic [1:0] rx_trig;
		logic [1:0] unused;
		logic       dma_mode;
		logic       tx_clr;
		logic       rx_clr;
		logic       fifo_en;
	} fifo_ctrl_t;

endpackage

// *** uart_fifo_dma_ready_control.sv ***
`timescale 1ns/100ps

module uart_fifo_dma_ready_control (
	// clock and reset
	input  wire logic        SYS_CLK,
	input  wire logic        RESETN,
	// avalon-mm slave
	input  wire logic [7:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	input  wire logic [31:0] AVS_WRITEDATA,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	// transmit shifter side
	input  wire logic        TX_SHIFT_REQ,
	output logic      [7:0]  TX_SHIFT_DATA,
	output logic             TX_SHIFT_STB,
	// receive shifter side
	input  wire logic        RX_CHAR_VALID,
	input  wire logic [7:0]  RX_CHAR_DATA,
	input  wire logic        RX_TIMEOUT,
	// dma ready pins and interrupt conditions
	output logic             TX_DMA_READY_PIN,
	output logic             MULTIFUNCTION_PIN,
	output logic             TX_INT,
	output logic             RX_INT
);

	// ********************************
	// bus decode
	// ********************************
	uart_dma_pkg::fifo_ctrl_t fifo_ctrl_reg;
	uart_dma_pkg::fifo_ctrl_t wr_ctrl;
	logic [7:0]  alt_function_reg;
	logic        wait_q;
	logic        req;
	logic        rd_acc;
	logic        wr_acc;
	logic        ctrl_wr;
	logic        mode1;
	logic        rx_sel;
	logic        tx_clr;
	logic        rx_clr;
	logic [4:0]  depth;
	logic [4:0]  trig;
	logic [31:0] rd_mux;
	logic        overrun_q;
	logic        rx_had_q;

	assign req     = AVS_READ | AVS_WRITE;
	assign rd_acc  = AVS_READ & ~wait_q;
	assign wr_acc  = AVS_WRITE & ~wait_q & AVS_BYTEENABLE[0];
	assign wr_ctrl = uart_dma_pkg::fifo_ctrl_t'(AVS_WRITEDATA[7:0]);
	assign ctrl_wr = wr_acc & (AVS_ADDRESS == uart_dma_pkg::OFS_FIFO_CTRL);
	assign mode1   = fifo_ctrl_reg.dma_mode & fifo_ctrl_reg.fifo_en;
	assign rx_sel  = alt_function_reg[uart_dma_pkg::ALT_SEL_LSB +: 2]
		== uart_dma_pkg::ALT_SEL_RX_RDY;
	assign depth   = fifo_ctrl_reg.fifo_en ? uart_dma_pkg::FIFO_DEPTH
		: uart_dma_pkg::HOLD_DEPTH;
	assign tx_clr  = ctrl_wr & ((wr_ctrl.fifo_en & wr_ctrl.tx_clr)
		| (wr_ctrl.fifo_en != fifo_ctrl_reg.fifo_en));
	assign rx_clr  = ctrl_wr & ((wr_ctrl.fifo_en & wr_ctrl.rx_clr)
		| (wr_ctrl.fifo_en != fifo_ctrl_reg.fifo_en));

	// one wait cycle, then the access edge
	always_ff @(posedge SYS_CLK or negedge RESETN)
	begin
		if (!RESETN)
			wait_q <= 1'b1;
		else
			wait_q <= ~(req & wait_q);
	end

	assign AVS_WAITREQUEST = wait_q;

	// ********************************
	// control registers
	// ********************************
	// per-instance control register, shared by transmit and receive
	always_ff @(posedge SYS_CLK or negedge RESETN)
	begin
		if (!RESETN)
			fifo_ctrl_reg <= uart_dma_pkg::fifo_ctrl_t'(uart_dma_pkg::FIFO_CTRL_RESET);
		else if (ctrl_wr)
		begin
			if (wr_ctrl.fifo_en)
			begin
				fifo_ctrl_reg.rx_trig  <= wr_ctrl.rx_trig;
				fifo_ctrl_reg.dma_mode <= wr_ctrl.dma_mode;
				fifo_ctrl_reg.fifo_en  <= 1'b1;
			end
			else
				fifo_ctrl_reg.fifo_en  <= 1'b0;
			fifo_ctrl_reg.unused <= 2'h0;
			fifo_ctrl_reg.tx_clr <= 1'b0;
			fifo_ctrl_reg.rx_clr <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RESETN)
	begin
		if (!RESETN)
			alt_function_reg <= uart_dma_pkg::ALT_FUNC_RESET;
		else if (wr_acc && AVS_ADDRESS == uart_dma_pkg::OFS_ALT_FUNC)
			alt_function_reg <= AVS_WRITEDATA[7:0];
	end

	always_comb
	begin
		unique case (fifo_ctrl_reg.rx_trig)
			2'h0: trig = uart_dma_pkg::TRIG_LVL_0;
			2'h1: trig = uart_dma_pkg::TRIG_LVL_1;
			2'h2: trig = uart_dma_pkg::TRIG_LVL_2;
			2'h3: trig = uart_dma_pkg::TRIG_LVL_3;
		endcase
	end

	// ********************************
	// transmit fifo / holding register
	// ********************************
	logic [7:0] tx_mem [16];
	logic [3:0] tx_wp;
	logic [3:0] tx_rp;
	logic [4:0] tx_cnt;
	logic       tx_push;
	logic       tx_pop;

	assign tx_push = wr_acc & (AVS_ADDRESS == uart_dma_pkg::OFS_TX_DATA)
		& (tx_cnt < depth) & ~tx_clr;
	assign tx_pop  = TX_SHIFT_REQ & (tx_cnt != 5'h00) & ~tx_clr;

	always_ff @(posedge SYS_CLK)
	begin
		if (tx_push)
			tx_mem[tx_wp] <= AVS_WRITEDATA[7:0];
	end

	always_ff @(posedge SYS_CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			tx_wp  <= 4'h0;
			tx_rp  <= 4'h0;
			tx_cnt <= 5'h00;
		end
		else if (tx_clr)
		begin
			tx_wp  <= 4'h0;
			tx_rp  <= 4'h0;
			tx_cnt <= 5'h00;
		end
		else
		begin
			tx_wp  <= tx_wp + 4'(tx_push);
			tx_rp  <= tx_rp + 4'(tx_pop);
			tx_cnt <= tx_cnt + 5'(tx_push) - 5'(tx_pop);
		end
	end

	always_ff @(posedge SYS_CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			TX_SHIFT_DATA <= 8'h00;
			TX_SHIFT_STB  <= 1'b0;
		end
		else
		begin
			TX_SHIFT_STB <= tx_pop;
			if (tx_pop)
				TX_SHIFT_DATA <= tx_mem[tx_rp];
		end
	end

	// ********************************
	// receive fifo / holding register
	// ********************************
	logic [7:0] rx_mem [16];
	logic [3:0] rx_wp;
	logic [3:0] rx_rp;
	logic [4:0] rx_cnt;
	logic       rx_push;
	logic       rx_pop;
	logic       rx_low_d;
	logic       rx_low_q;

	assign rx_push = RX_CHAR_VALID & (rx_cnt < depth) & ~rx_clr;
	assign rx_pop  = rd_acc & (AVS_ADDRESS == uart_dma_pkg::OFS_RX_DATA)
		& rx_had_q & (rx_cnt != 5'h00) & ~rx_clr;

	always_ff @(posedge SYS_CLK)
	begin
		if (rx_push)
			rx_mem[rx_wp] <= RX_CHAR_DATA;
	end

	always_ff @(posedge SYS_CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			rx_wp  <= 4'h0;
			rx_rp  <= 4'h0;
			rx_cnt <= 5'h00;
		end
		else if (rx_clr)
		begin
			rx_wp  <= 4'h0;
			rx_rp  <= 4'h0;
			rx_cnt <= 5'h00;
		end
		else
		begin
			rx_wp  <= rx_wp + 4'(rx_push);
			rx_rp  <= rx_rp + 4'(rx_pop);
			rx_cnt <= rx_cnt + 5'(rx_push) - 5'(rx_pop);
		end
	end

	// overrun: set wins over the status-read clear
	always_ff @(posedge SYS_CLK or negedge RESETN)
	begin
		if (!RESETN)
			overrun_q <= 1'b0;
		else if (RX_CHAR_VALID && rx_cnt >= depth)
			overrun_q <= 1'b1;
		else if (rd_acc && AVS_ADDRESS == uart_dma_pkg::OFS_STATUS)
			overrun_q <= 1'b0;
	end

	// ********************************
	// read data
	// ********************************
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		unique case (AVS_ADDRESS)
			uart_dma_pkg::OFS_ALT_FUNC: rd_mux[7:0] = alt_function_reg;
			uart_dma_pkg::OFS_RX_DATA:
				if (rx_cnt != 5'h00)
					rd_mux[7:0] = rx_mem[rx_rp];
			uart_dma_pkg::OFS_STATUS:
			begin
				rd_mux[uart_dma_pkg::ST_TX_CNT_LSB +: 5] = tx_cnt;
				rd_mux[uart_dma_pkg::ST_RX_CNT_LSB +: 5] = rx_cnt;
				rd_mux[uart_dma_pkg::ST_TX_INT]          = TX_INT;
				rd_mux[uart_dma_pkg::ST_RX_INT]          = RX_INT;
				rd_mux[uart_dma_pkg::ST_OVERRUN]         = overrun_q;
				rd_mux[uart_dma_pkg::ST_TX_PIN]          = TX_DMA_READY_PIN;
				rd_mux[uart_dma_pkg::ST_MF_PIN]          = MULTIFUNCTION_PIN;
			end
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			AVS_READDATA <= 32'h0000_0000;
			rx_had_q     <= 1'b0;
		end
		else if (AVS_READ && wait_q)
		begin
			AVS_READDATA <= rd_mux;
			rx_had_q     <= rx_cnt != 5'h00;
		end
	end

	// ********************************
	// dma ready and interrupt outputs
	// ********************************
	assign rx_low_d = (rx_cnt != 5'h00)
		& (rx_low_q | (rx_cnt >= trig) | RX_TIMEOUT);

	always_ff @(posedge SYS_CLK or negedge RESETN)
	begin
		if (!RESETN)
			rx_low_q <= 1'b0;
		else
			rx_low_q <= mode1 & rx_low_d;
	end

	always_ff @(posedge SYS_CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			TX_DMA_READY_PIN  <= 1'b1;
			MULTIFUNCTION_PIN <= 1'b1;
		end
		else
		begin
			if (mode1)
				TX_DMA_READY_PIN <= tx_cnt >= depth;
			else
				TX_DMA_READY_PIN <= tx_cnt != 5'h00;
			if (!rx_sel)
				MULTIFUNCTION_PIN <= 1'b1;
			else if (mode1)
				MULTIFUNCTION_PIN <= ~rx_low_d;
			else
				MULTIFUNCTION_PIN <= rx_cnt == 5'h00;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			TX_INT <= 1'b0;
			RX_INT <= 1'b0;
		end
		else if (mode1)
		begin
			TX_INT <= tx_cnt < depth;
			RX_INT <= rx_cnt >= trig;
		end
		else
		begin
			TX_INT <= tx_cnt == 5'h00;
			RX_INT <= rx_cnt != 5'h00;
		end
	end

	// ********************************
	// assertions
	// ********************************
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RESETN);

	sequence s_tx_write_mode0;
		tx_push && !mode1 && !ctrl_wr;
	endsequence

	sequence s_tx_kept_mode0;
		!mode1 && !tx_clr;
	endsequence

	a_mode_bit_gated: assert property (ctrl_wr && !wr_ctrl.fifo_en |=>
		$stable(fifo_ctrl_reg.dma_mode) && $stable(fifo_ctrl_reg.rx_trig))
		else $error("control bits changed without fifo enable");
	a_mode_next_clock: assert property (ctrl_wr && wr_ctrl.fifo_en |=>
		fifo_ctrl_reg.dma_mode == $past(wr_ctrl.dma_mode))
		else $error("dma mode not taken at write");
	a_unused_bits_zero: assert property (fifo_ctrl_reg.unused == 2'h0)
		else $error("unused control bits set");
	a_tx_empty_low: assert property (!mode1 && tx_cnt == 5'h00 |=>
		!TX_DMA_READY_PIN)
		else $error("transmit-ready not low when empty");
	a_tx_first_write: assert property (s_tx_write_mode0 ##1 s_tx_kept_mode0 |=>
		TX_DMA_READY_PIN)
		else $error("transmit-ready not high after write");
	a_rx_held_low: assert property (rx_sel && !mode1 && rx_cnt != 5'h00 |=>
		!MULTIFUNCTION_PIN)
		else $error("receive-ready not low with data");
	a_rx_empty_high: assert property (!mode1 && rx_cnt == 5'h00 |=>
		MULTIFUNCTION_PIN)
		else $error("receive-ready not released when empty");
	a_mf_unselected: assert property (!rx_sel |=> MULTIFUNCTION_PIN)
		else $error("multifunction pin driven while not selected");
	a_tx_int_block: assert property (mode1 && tx_cnt < depth |=> TX_INT)
		else $error("transmit interrupt missing with free space");
	a_tx_ready_block: assert property (mode1 |=>
		TX_DMA_READY_PIN == ($past(tx_cnt) == uart_dma_pkg::FIFO_DEPTH))
		else $error("transmit-ready wrong in block mode");
	a_rx_int_trigger: assert property (mode1 && rx_cnt == trig |=> RX_INT)
		else $error("receive interrupt missing at trigger");
	a_rx_fill_past: assert property (rx_push && !rx_pop && !rx_clr |=>
		rx_cnt == $past(rx_cnt) + 5'h01)
		else $error("receive fifo stopped filling");
	a_rx_trig_low: assert property (rx_sel && mode1 && rx_cnt >= trig |=>
		!MULTIFUNCTION_PIN)
		else $error("receive-ready not low at trigger");
	a_rx_timeout_hold: assert property (rx_sel && mode1 && RX_TIMEOUT
		&& rx_cnt != 5'h00 ##1 (rx_sel && mode1 && rx_cnt != 5'h00) |=> !MULTIFUNCTION_PIN)
		else $error("receive-ready released before empty");

endmodule // uart_fifo_dma_ready_control

// *** uart_fifo_dma_ready_control_tb.sv ***
`timescale 1ns/100ps

module uart_fifo_dma_ready_control_tb;
	typedef struct packed {
		logic [1:0] trig;
		logic [4:0] n;
		logic       mf;
		logic       ri;
	} row_t;

	logic        SYS_CLK = 1'b0;
	logic        RESETN = 1'b0;
	logic [7:0]  AVS_ADDRESS = 8'h00;
	logic        AVS_READ = 1'b0;
	logic        AVS_WRITE = 1'b0;
	logic [3:0]  AVS_BYTEENABLE = 4'hF;
	logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
	logic [31:0] AVS_READDATA;
	logic        AVS_WAITREQUEST;
	logic        TX_SHIFT_REQ, TX_SHIFT_STB, RX_CHAR_VALID, rx_busy;
	logic [7:0]  TX_SHIFT_DATA, RX_CHAR_DATA, tx_last, ch, ch_next = 8'hA0;
	logic        RX_TIMEOUT = 1'b0;
	logic        TX_DMA_READY_PIN, MULTIFUNCTION_PIN, TX_INT, RX_INT;
	logic        rx_go = 1'b0;
	logic        drain = 1'b0;
	logic [4:0]  rx_num = 5'h00;
	logic [31:0] q;
	int          n_errors = 0;
	int          total_checks = 0;
	row_t        rows [7] = '{'{2'h0, 5'h01, 1'b0, 1'b1}, '{2'h1, 5'h03, 1'b1, 1'b0},
		'{2'h1, 5'h04, 1'b0, 1'b1}, '{2'h2, 5'h07, 1'b1, 1'b0}, '{2'h2, 5'h08, 1'b0, 1'b1},
		'{2'h3, 5'h0D, 1'b1, 1'b0}, '{2'h3, 5'h0E, 1'b0, 1'b1}};

	always #2.5 SYS_CLK = ~SYS_CLK;

	uart_fifo_dma_ready_control i_uart_fifo_dma_ready_control (
		.SYS_CLK(SYS_CLK), .RESETN(RESETN), .AVS_ADDRESS(AVS_ADDRESS),
		.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(AVS_BYTEENABLE),
		.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST), .TX_SHIFT_REQ(TX_SHIFT_REQ),
		.TX_SHIFT_DATA(TX_SHIFT_DATA), .TX_SHIFT_STB(TX_SHIFT_STB),
		.RX_CHAR_VALID(RX_CHAR_VALID), .RX_CHAR_DATA(RX_CHAR_DATA),
		.RX_TIMEOUT(RX_TIMEOUT), .TX_DMA_READY_PIN(TX_DMA_READY_PIN),
		.MULTIFUNCTION_PIN(MULTIFUNCTION_PIN), .TX_INT(TX_INT), .RX_INT(RX_INT));

	serial_side_model i_serial_side_model (
		.clk(SYS_CLK), .rst_n(RESETN), .rx_go(rx_go), .rx_num(rx_num), .drain(drain),
		.rx_busy(rx_busy), .tx_last(tx_last), .tx_stb(TX_SHIFT_STB),
		.tx_data(TX_SHIFT_DATA), .tx_req(TX_SHIFT_REQ), .rx_valid(RX_CHAR_VALID),
		.rx_data(RX_CHAR_DATA));

	// ********************************
	// helpers
	// ********************************
	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic settle();
		repeat (3) @(posedge SYS_CLK);
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] rd);
		int k;
		@(posedge SYS_CLK);
		AVS_ADDRESS <= a;
		AVS_WRITE <= w;
		AVS_READ <= ~w;
		AVS_WRITEDATA <= {24'h00_0000, d};
		k = 0;
		do
		begin
			@(posedge SYS_CLK);
			k++;
		end
		while (AVS_WAITREQUEST !== 1'b0 && k < 50);
		rd = AVS_READDATA;
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
		if (k >= 50)
		begin
			n_errors++;
			end_sim();
		end
	endtask

	task automatic rx_send(input logic [4:0] n);
		int k;
		@(posedge SYS_CLK);
		rx_go <= 1'b1;
		rx_num <= n;
		@(posedge SYS_CLK);
		rx_go <= 1'b0;
		k = 0;
		do
		begin
			@(posedge SYS_CLK);
			k++;
		end
		while (rx_busy && k < 40);
		ch_next = ch_next + 8'(n);
		settle();
		if (k >= 40)
		begin
			n_errors++;
			end_sim();
		end
	endtask

	// ********************************
	// sequence
	// ********************************
	initial
	begin
		repeat (4) @(posedge SYS_CLK);
		chk("reset pins", {TX_DMA_READY_PIN, MULTIFUNCTION_PIN, TX_INT, RX_INT}, 4'hC);
		RESETN <= 1'b1;
		settle();
		chk("idle pins", {TX_DMA_READY_PIN, MULTIFUNCTION_PIN, TX_INT, RX_INT}, 4'h6);
		bus(1'b0, uart_dma_pkg::OFS_FIFO_CTRL, 8'h00, q);
		chk("ctrl read", q, 32'h0000_0000);
		bus(1'b0, 8'h20, 8'h00, q);
		chk("unmapped", q, 32'h0000_0000);
		bus(1'b1, uart_dma_pkg::OFS_ALT_FUNC, 8'h02, q);
		foreach (rows[i])
		begin
			bus(1'b1, uart_dma_pkg::OFS_FIFO_CTRL, {rows[i].trig, 6'h0B}, q);
			rx_send(rows[i].n);
			chk("rx level", {MULTIFUNCTION_PIN, RX_INT}, {rows[i].mf, rows[i].ri});
		end
		// time-out below trigger
		bus(1'b1, uart_dma_pkg::OFS_FIFO_CTRL, 8'hCB, q);
		rx_send(5'h02);
		chk("no timeout", MULTIFUNCTION_PIN, 1'b1);
		@(posedge SYS_CLK);
		RX_TIMEOUT <= 1'b1;
		@(posedge SYS_CLK);
		RX_TIMEOUT <= 1'b0;
		settle();
		chk("timeout", MULTIFUNCTION_PIN, 1'b0);
		bus(1'b0, uart_dma_pkg::OFS_RX_DATA, 8'h00, q);
		settle();
		chk("timeout hold", MULTIFUNCTION_PIN, 1'b0);
		bus(1'b0, uart_dma_pkg::OFS_RX_DATA, 8'h00, q);
		settle();
		chk("timeout end", MULTIFUNCTION_PIN, 1'b1);
		// block mode transmit fill
		bus(1'b1, uart_dma_pkg::OFS_FIFO_CTRL, 8'h0D, q);
		for (int i = 0; i < 17; i++)
		begin
			bus(1'b1, uart_dma_pkg::OFS_TX_DATA, 8'(i), q);
			settle();
			if (i == 14) chk("tx free", {TX_DMA_READY_PIN, TX_INT}, 2'h1);
			if (i == 15) chk("tx full", {TX_DMA_READY_PIN, TX_INT}, 2'h2);
		end
		bus(1'b0, uart_dma_pkg::OFS_STATUS, 8'h00, q);
		chk("tx count", q[uart_dma_pkg::ST_TX_CNT_LSB +: 5], 5'h10);
		drain <= 1'b1;
		repeat (6) @(posedge SYS_CLK);
		drain <= 1'b0;
		settle();
		chk("tx drained", TX_DMA_READY_PIN, 1'b0);
		// receive past trigger until full
		bus(1'b1, uart_dma_pkg::OFS_FIFO_CTRL, 8'h0B, q);
		rx_send(5'h11);
		bus(1'b0, uart_dma_pkg::OFS_STATUS, 8'h00, q);
		chk("rx full", {q[uart_dma_pkg::ST_OVERRUN], q[12:8]}, 6'h30);
		// single-character transmit
		bus(1'b1, uart_dma_pkg::OFS_FIFO_CTRL, 8'h07, q);
		bus(1'b1, uart_dma_pkg::OFS_TX_DATA, 8'h5A, q);
		settle();
		chk("tx loaded", {TX_DMA_READY_PIN, TX_INT}, 2'h2);
		drain <= 1'b1;
		repeat (6) @(posedge SYS_CLK);
		drain <= 1'b0;
		settle();
		chk("tx empty", {TX_DMA_READY_PIN, TX_INT, tx_last}, 10'h15A);
		// single-character receive, function not yet selected
		bus(1'b1, uart_dma_pkg::OFS_ALT_FUNC, 8'h00, q);
		ch = ch_next;
		rx_send(5'h01);
		chk("mf unselected", {MULTIFUNCTION_PIN, RX_INT}, 2'h3);
		bus(1'b1, uart_dma_pkg::OFS_ALT_FUNC, 8'h02, q);
		settle();
		chk("rx held", MULTIFUNCTION_PIN, 1'b0);
		bus(1'b0, uart_dma_pkg::OFS_RX_DATA, 8'h00, q);
		chk("rx char", q, {24'h00_0000, ch});
		settle();
		chk("rx gone", {MULTIFUNCTION_PIN, RX_INT}, 2'h2);
		// fifos disabled: holding register only, second write dropped
		bus(1'b1, uart_dma_pkg::OFS_FIFO_CTRL, 8'h08, q);
		bus(1'b1, uart_dma_pkg::OFS_TX_DATA, 8'hC3, q);
		bus(1'b1, uart_dma_pkg::OFS_TX_DATA, 8'h3C, q);
		settle();
		chk("hold loaded", {TX_DMA_READY_PIN, TX_INT}, 2'h2);
		bus(1'b0, uart_dma_pkg::OFS_STATUS, 8'h00, q);
		chk("hold depth", q[uart_dma_pkg::ST_TX_CNT_LSB +: 5], 5'h01);
		drain <= 1'b1;
		repeat (6) @(posedge SYS_CLK);
		drain <= 1'b0;
		settle();
		chk("hold empty", {TX_DMA_READY_PIN, TX_INT, tx_last}, 10'h1C3);
		// write without low byte lane is ignored
		@(posedge SYS_CLK);
		AVS_BYTEENABLE <= 4'h0;
		bus(1'b1, uart_dma_pkg::OFS_ALT_FUNC, 8'h00, q);
		@(posedge SYS_CLK);
		AVS_BYTEENABLE <= 4'hF;
		bus(1'b0, uart_dma_pkg::OFS_ALT_FUNC, 8'h00, q);
		chk("lane ignored", q, 32'h0000_0002);
		end_sim();
	end
endmodule // uart_fifo_dma_ready_control_tb
